//--- cpu_flag_pkg.sv
// Package for the status-flag and arithmetic block: offsets, fields, reset values.
// Assumes a 32-bit APB master clocked by pclk.
package cpu_flag_pkg;

  localparam logic [11:0] ps_off     = 12'h000;
  localparam logic [11:0] op_off     = 12'h004;
  localparam logic [11:0] result_off = 12'h008;
  localparam logic [11:0] irq_off    = 12'h00C;
  localparam logic [11:0] dir_off    = 12'h010;
  localparam logic [11:0] cfg_off    = 12'h014;
  localparam logic [11:0] cycles_off = 12'h018;

  // Status word bit positions
  localparam int c_bit = 0;
  localparam int z_bit = 1;
  localparam int i_bit = 2;
  localparam int d_bit = 3;
  localparam int t_bit = 5;
  localparam int v_bit = 6;
  localparam int n_bit = 7;

  localparam logic [7:0] ps_reset    = 8'h04;
  localparam logic [7:0] irq_reset   = 8'h00;
  localparam logic [7:0] dir_reset   = 8'h00;
  localparam logic [1:0] wait_stretch = 2'h2;

  typedef enum logic [2:0] {
    op_adc = 3'h0,
    op_sbc = 3'h1,
    op_mul = 3'h2,
    op_div = 3'h3,
    op_sec = 3'h4,
    op_clc = 3'h5,
    op_cld = 3'h6,
    op_nop = 3'h7
  } opcode_type;

  typedef struct packed {
    logic [7:0] n_cycles;
    opcode_type opcode;
    logic [7:0] b;
    logic [7:0] a;
  } op_word_type;

  typedef struct packed {
    logic [15:0] value;
  } result_type;

  typedef enum logic [2:0] {
    st_idle  = 3'b001,
    st_exec  = 3'b010,
    st_wait  = 3'b100
  } state_type;

endpackage

//--- cpu_status_flag_decimal_alu.sv
// Status word, binary/decimal add and subtract, multiply/divide, request and
// direction registers with cycle-accurate execution timing, on an APB slave.
// Assumes pclk is the internal clock and software issues operations over APB.
// Notes on behaviour
// - After reset the interrupt-disable flag is one; other status bits are unspecified.
// - With decimal flag set, add and subtract work in BCD.
// - Negative, overflow and zero flags mean nothing after decimal arithmetic.
// - Multiply and divide ignore the index-X and decimal flags.
// - Multiply and divide leave the status word untouched.
// - Request-bit writes land one instruction later than the write.
// - Direction registers are write-only; reads return zero.
// - Execution lasts cycle count times the internal clock period; a count of zero runs one cycle.
// - Each multichannel RAM wait doubles the affected clock cycle.
//
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module cpu_status_flag_decimal_alu
  import cpu_flag_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ram_wait,
  output logic             busy,
  output logic [7:0]       port_direction
);
  import cpu_flag_pkg::*;

  logic [7:0]  processor_status_word;
  logic [7:0]  irq_bits;
  logic [7:0]  irq_pending;
  logic        irq_pending_valid;
  logic [1:0]  cfg;
  result_type  result;
  op_word_type op;
  state_type   state;
  logic [7:0]  cycle_left;
  logic        stretch;
  logic [15:0] cycles_spent;

  logic access;
  logic wr;
  logic mapped;
  logic op_issue;
  logic op_done;
  assign access   = psel && penable;
  assign wr       = access && pwrite;
  assign mapped   = paddr == ps_off || paddr == op_off || paddr == result_off || paddr == irq_off ||
                    paddr == dir_off || paddr == cfg_off || paddr == cycles_off;
  // Op writes stall while busy so an instruction is never dropped
  assign pready   = !(psel && pwrite && paddr == op_off && state != st_idle);
  assign pslverr  = access && !mapped;
  assign op_issue = wr && pready && paddr == op_off;
  assign op_done  = state == st_exec && cycle_left <= 8'h01 && !(cfg[0] && ram_wait && !stretch);
  assign busy     = state != st_idle;

  // BCD digit adjust on one byte, used by add only; subtract uses bcd_sub
  function automatic logic [8:0] bcd_add(input logic [7:0] a, input logic [7:0] b, input logic cin);
    logic [4:0] lo;
    logic [4:0] hi;
    logic       c1;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    c1 = lo > 5'h09;
    if (c1) lo = lo + 5'h06;
    hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, c1};
    if (hi > 5'h09) hi = hi + 5'h06;
    return {hi > 5'h0F || hi[4], hi[3:0], lo[3:0]};
  endfunction

  function automatic logic [8:0] bcd_sub(input logic [7:0] a, input logic [7:0] b, input logic cin);
    logic [4:0] lo;
    logic [4:0] hi;
    logic       borrow;
    lo     = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ~cin};
    borrow = lo[4];
    if (borrow) lo = lo - 5'h06;
    hi = {1'b0, a[7:4]} - {1'b0, b[7:4]} - {4'h0, borrow};
    if (hi[4]) hi = hi - 5'h06;
    return {~hi[4], hi[3:0], lo[3:0]};
  endfunction

  logic [8:0]  next_sum;
  logic [7:0]  next_ps;
  logic [15:0] next_value;
  always_comb begin
    next_ps    = processor_status_word;
    next_value = result.value;
    next_sum   = 9'h000;
    case (op.opcode)
      op_adc: begin
        if (processor_status_word[d_bit]) next_sum = bcd_add(op.a, op.b, processor_status_word[c_bit]);
        else next_sum = {1'b0, op.a} + {1'b0, op.b} + {8'h00, processor_status_word[c_bit]};
        next_value = {8'h00, next_sum[7:0]};
        next_ps[c_bit] = next_sum[8];
        // Flags below are computed from the binary view; meaningless in decimal mode
        next_ps[z_bit] = next_sum[7:0] == 8'h00;
        next_ps[n_bit] = next_sum[7];
        next_ps[v_bit] = (op.a[7] == op.b[7]) && (next_sum[7] != op.a[7]);
      end
      op_sbc: begin
        if (processor_status_word[d_bit]) next_sum = bcd_sub(op.a, op.b, processor_status_word[c_bit]);
        else next_sum = {1'b0, op.a} + {1'b0, ~op.b} + {8'h00, processor_status_word[c_bit]};
        next_value = {8'h00, next_sum[7:0]};
        next_ps[c_bit] = next_sum[8];
        next_ps[z_bit] = next_sum[7:0] == 8'h00;
        next_ps[n_bit] = next_sum[7];
        next_ps[v_bit] = (op.a[7] != op.b[7]) && (next_sum[7] != op.a[7]);
      end
      // No flag term in either path; status word kept as is
      op_mul: next_value = {8'h00, op.a} * {8'h00, op.b};
      op_div: begin
        if (op.b == 8'h00) next_value = 16'hFFFF;
        else next_value = {op.a % op.b, op.a / op.b};
      end
      op_sec: next_ps[c_bit] = 1'b1;
      op_clc: next_ps[c_bit] = 1'b0;
      op_cld: next_ps[d_bit] = 1'b0;
      default: ;
    endcase
  end

  // Execution sequencer: one internal cycle per pclk, doubled on a wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state      <= st_idle;
      cycle_left <= 8'h00;
      stretch    <= 1'b0;
    end else begin
      case (state)
        st_idle: if (op_issue) begin
          state      <= st_exec;
          cycle_left <= pwdata[26:19] == 8'h00 ? 8'h01 : pwdata[26:19];
          stretch    <= 1'b0;
        end
        st_exec: begin
          if (cfg[0] && ram_wait && !stretch) stretch <= 1'b1;
          else begin
            stretch <= 1'b0;
            if (cycle_left <= 8'h01) state <= st_idle;
            else cycle_left <= cycle_left - 8'h01;
          end
        end
        default: state <= st_idle;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cycles_spent <= 16'h0000;
    else if (op_issue) cycles_spent <= 16'h0000;
    else if (state == st_exec) cycles_spent <= cycles_spent + 16'h0001;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) op <= '0;
    else if (op_issue) op <= pwdata[26:0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) processor_status_word <= ps_reset;
    else if (op_done) processor_status_word <= next_ps;
    else if (wr && paddr == ps_off && state == st_idle) processor_status_word <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) result <= '0;
    else if (op_done) result <= next_value;
  end

  // Request bits land only when the next instruction completes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_bits          <= irq_reset;
      irq_pending       <= irq_reset;
      irq_pending_valid <= 1'b0;
    end else begin
      if (op_done && irq_pending_valid) begin
        irq_bits          <= irq_pending;
        irq_pending_valid <= 1'b0;
      end
      if (wr && paddr == irq_off) begin
        irq_pending       <= pwdata[7:0];
        irq_pending_valid <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) port_direction <= dir_reset;
    else if (wr && paddr == dir_off) port_direction <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cfg <= 2'h0;
    else if (wr && paddr == cfg_off) cfg <= pwdata[1:0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite) begin
      case (paddr)
        ps_off:     prdata <= {24'h000000, processor_status_word};
        op_off:     prdata <= {5'h00, op};
        result_off: prdata <= {16'h0000, result.value};
        irq_off:    prdata <= {24'h000000, irq_bits};
        dir_off:    prdata <= 32'h0000_0000;
        cfg_off:    prdata <= {29'h0, busy, cfg};
        cycles_off: prdata <= {16'h0000, cycles_spent};
        default:    prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule // cpu_status_flag_decimal_alu
`default_nettype wire

//--- cpu_status_flag_decimal_alu_chk.sv
// Checker for the status-flag block: APB answer, op busy timing, direction port.
// Assumes it is bound to the block's top and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module cpu_status_flag_decimal_alu_chk
  import cpu_flag_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        ram_wait,
  input wire logic        busy,
  input wire logic [7:0]  port_direction
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic opw;
  assign acc = psel && penable;
  assign opw = acc && pwrite && paddr == op_off;
  property p_stall; opw && busy |-> !pready; endproperty
  a_stall: assert property (p_stall) else $error("op write not stalled");
  property p_ready; acc && !(opw && busy) |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("unexpected wait state");
  property p_err; acc && paddr > 12'h018 |-> pslverr && (pwrite || prdata == 32'h0); endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");
  property p_dir_rd; acc && !pwrite && paddr == dir_off |-> prdata == 32'h0; endproperty
  a_dir_rd: assert property (p_dir_rd) else $error("direction read not zero");
  property p_dir_wr; acc && pwrite && paddr == dir_off |=> port_direction == $past(pwdata[7:0]); endproperty
  a_dir_wr: assert property (p_dir_wr) else $error("direction write lost");
  property p_start; opw && pready |=> busy; endproperty
  a_start: assert property (p_start) else $error("op did not start");
  property p_len; opw && pready && pwdata[26:19] == 8'h03 |=> busy [*3]; endproperty
  a_len: assert property (p_len) else $error("op ended early");
  property p_cause; $rose(busy) |-> $past(opw && pready); endproperty
  a_cause: assert property (p_cause) else $error("busy without op");
endmodule // cpu_status_flag_decimal_alu_chk
`default_nettype wire

//--- cpu_status_flag_decimal_alu_tb.sv
// Testbench for the status-flag block: APB reads checked against a queue of notes.
// Assumes the package, design and checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
module cpu_status_flag_decimal_alu_tb;
  import cpu_flag_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ram_wait = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, eq[$], mq[$], vq[$];
  logic        pready, pslverr, busy;
  logic [7:0]  port_direction, a, b, s;
  int          err_total = 0, n_compared = 0, c, nt[3] = '{0, 1, 3};
  cpu_status_flag_decimal_alu cpu_status_flag_decimal_alu_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ram_wait(ram_wait), .busy(busy), .port_direction(port_direction));
  always #4 pclk = ~pclk;
  task automatic chk(input logic [31:0] got, exp, m);
    n_compared++;
    if ((got & m) !== (exp & m)) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("err_total %0d n_compared %0d", err_total, n_compared);
    if (err_total == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [11:0] ad, input logic [31:0] d);
    // A release still pending from the last call costs one idle cycle, never a double drive
    if (psel === 1'b1) @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rd(input logic [11:0] ad, input logic [31:0] e, m);
    eq.push_back(e);
    mq.push_back(m);
    vq.push_back({31'h0, !(ad inside {ps_off, op_off, result_off, irq_off, dir_off, cfg_off, cycles_off})});
    xfer(0, ad, 0);
  endtask
  // Counts busy cycles; a stalled op write is absorbed by xfer
  task automatic op(input logic [2:0] o, input logic [7:0] x, y, n);
    xfer(1, op_off, {5'h0, n, o, y, x});
    c = 0;
    repeat (600) begin
      #1;
      if (busy === 1'b1) c++;
      else if (c > 0) break;
      @(posedge pclk);
    end
    @(posedge pclk);
  endtask
  always @(posedge pclk)
    if ((psel && penable && pready && !pwrite) === 1'b1) begin
      chk(prdata, eq.pop_front(), mq.pop_front());
      chk({31'h0, pslverr}, vq.pop_front(), 32'h1);
    end
  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    complete_run;
  end
  initial begin
    s = 8'($urandom(42));
    repeat (4) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    rd(ps_off, 32'h04, 32'h04);
    xfer(1, ps_off, 32'h00);
    op(op_adc, 8'hF0, 8'h20, 8'h02);
    rd(result_off, 32'h10, 32'hFF);
    rd(ps_off, 32'h01, 32'h01);
    xfer(1, ps_off, 32'h08);
    op(op_adc, 8'h45, 8'h38, 8'h02);
    rd(result_off, 32'h83, 32'hFF);
    rd(ps_off, 32'h08, 32'h09);
    xfer(1, ps_off, 32'h09);
    op(op_sbc, 8'h38, 8'h45, 8'h02);
    rd(result_off, 32'h93, 32'hFF);
    rd(ps_off, 32'h08, 32'h09);
    op(op_nop, 8'h00, 8'h00, 8'h01);
    op(op_sec, 8'h00, 8'h00, 8'h01);
    rd(ps_off, 32'h09, 32'h09);
    op(op_cld, 8'h00, 8'h00, 8'h01);
    op(op_clc, 8'h00, 8'h00, 8'h01);
    rd(ps_off, 32'h00, 32'h09);
    repeat (3) begin
      a = 8'($urandom);
      b = 8'($urandom | 1);
      s = 8'(($urandom | 8'h28) & 8'hEF);
      ram_wait <= 1'($urandom);
      xfer(1, ps_off, {24'h0, s});
      op(op_mul, a, b, 8'h04);
      rd(result_off, a * b, 32'hFFFF);
      rd(ps_off, s, 32'hEF);
      op(op_div, a, b, 8'h04);
      rd(result_off, {a % b, a / b}, 32'hFFFF);
      rd(ps_off, s, 32'hEF);
    end
    for (int k = 0; k < 2; k++) begin
      ram_wait <= k[0];
      xfer(1, cfg_off, k);
      foreach (nt[i]) begin
        op(op_nop, 8'h00, 8'h00, nt[i][7:0]);
        chk(c, (nt[i] > 0 ? nt[i] : 1) << k, 32'hFF);
      end
    end
    xfer(1, cfg_off, 32'h0);
    a = 8'($urandom);
    xfer(1, dir_off, {24'h0, a});
    rd(dir_off, 32'h0, 32'hFFFFFFFF);
    chk(port_direction, a, 32'hFF);
    rd(12'h100, 32'h0, 32'hFFFFFFFF);
    xfer(1, irq_off, 32'h5A);
    rd(irq_off, 32'h00, 32'hFF);
    // Second op write lands while busy, so pready must hold it off
    xfer(1, op_off, 32'h002F0000);
    op(op_nop, 8'h00, 8'h00, 8'h01);
    chk(c, 32'h1, 32'hFF);
    rd(irq_off, 32'h5A, 32'hFF);
    complete_run;
  end
endmodule // cpu_status_flag_decimal_alu_tb
bind cpu_status_flag_decimal_alu cpu_status_flag_decimal_alu_chk cpu_status_flag_decimal_alu_chk_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ram_wait(ram_wait), .busy(busy),
  .port_direction(port_direction));
`default_nettype wire
